/* File: banked_data_memory_addressing_test.sv */
`timescale 1ns/1ps
module banked_data_memory_addressing_test;
   reg clk_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg wdt_pd_reset_i = 1'b0;
   wire [2:0] op_w;
   wire [7:0] addr_w, wdata_w, rdata_o, wreg_o, bank_o, ptr0_o, ptr1_o, dadr_w, ddat_w;
   wire rvalid_o, dwe_w;
   integer m [0:3327];
   integer err_total = 0, compares = 0, seed = 32'h8cf7, i, b, a, d, e_rd = -1, e_dw = -1;
   bdma_cpu u_cpu (.op_o(op_w), .addr_o(addr_w), .wdata_o(wdata_w));
   bdma_core dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .wdt_pd_reset_i(wdt_pd_reset_i),
      .op_i(op_w), .addr_i(addr_w), .wdata_i(wdata_w), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .wreg_o(wreg_o), .bank_o(bank_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o), .disp_we_o(dwe_w),
      .disp_addr_o(dadr_w), .disp_data_o(ddat_w));
   // 100 MHz clock
   initial forever #5 clk_i = ~clk_i;
   // Location reached by an access, -1 where nothing answers
   function integer eff(input integer x);
      integer p;
      begin
         p = (x == 0) ? m[1] : m[3];
         if (x != 0 && x != 2) eff = x;
         else if (p == 0 || p == 2) eff = -1;
         else if (p < 64 || x == 0) eff = p;
         else if (m[4] > 12 || (m[4] == 1 && p > 191)) eff = -1;
         else eff = m[4] * 256 + p;
      end
   endfunction
   task chk(input [31:0] s, input [31:0] e);
      begin
         compares = compares + 1;
         if (s !== e) begin
            err_total = err_total + 1;
            $display("unexpected at %0t: saw %h expected %h", $time, s, e);
         end
      end
   endtask
   // Check the previous request, then issue the next one back to back
   task op(input integer o, input integer x, input integer d);
      integer l, v;
      begin
         @(negedge clk_i);
         chk({rvalid_o, dwe_w}, {e_rd >= 0, e_dw >= 0});
         if (e_rd >= 0) chk(rdata_o, e_rd);
         if (e_dw >= 0) chk({dadr_w, ddat_w}, e_dw);
         l = eff(x);
         v = (l < 0 || (l > 5 && l < 64)) ? 0 : m[l];
         e_rd = (o == 1) ? v : -1;
         e_dw = -1;
         if (o == 5) m[5] = v;
         if (o == 7) m[5] = (m[5] + v) & 255;
         v = (o == 2) ? d : (o == 3) ? v + 1 : (o == 4) ? v - 1 : m[5];
         if ((o > 1 && o < 5) || o == 6) begin
            if (l > 63 || (l > 0 && l < 6)) m[l] = v & 255;
            if (l > 319 && l < 448) e_dw = (l - 256) * 256 + (v & 255);
         end
         u_cpu.put(o, x, d);
      end
   endtask
   // Two idle cycles let the register mirrors settle
   task sync;
      begin
         op(0, 0, 0);
         op(0, 0, 0);
         chk({wreg_o, bank_o, ptr0_o, ptr1_o}, {m[5][7:0], m[4][7:0], m[1][7:0], m[3][7:0]});
      end
   endtask
   // Settle the last request and go idle, so nothing is pending across reset
   task rst(input integer w, input integer n);
      begin
         op(0, 0, 0);
         rst_n_i = 1'b0;
         wdt_pd_reset_i = w;
         repeat (n) @(negedge clk_i);
         rst_n_i = 1'b1;
         wdt_pd_reset_i = 1'b0;
         m[1] = 0;
         m[3] = 0;
         m[5] = 0;
         if (w == 0) m[4] = 0;
      end
   endtask
   task complete_run;
      begin
         $display("mismatches %0d comparisons %0d", err_total, compares);
         if (err_total == 0 && compares > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   // Fill every bank, run directed cases, then random traffic with resets
   initial begin
      rst(0, 5);
      for (b = 0; b < 13; b = b + 1) begin
         op(2, 4, b);
         for (a = 64; a < 256; a = a + 1) begin
            op(2, 3, a);
            op(2, 2, $random(seed) & 255);
         end
      end
      op(2, 4, 1);
      op(2, 3, 8'h50);
      sync;
      op(2, 2, 8'hAA);
      op(1, 2, 0);
      op(2, 4, 13);
      op(1, 2, 0);
      op(2, 1, 0);
      op(1, 0, 0);
      for (i = 0; i < 4000; i = i + 1) begin
         a = $random(seed) & 255;
         b = $random(seed) & 7;
         d = $random(seed) & 255;
         if (a > 127) a = a & 7;
         if (eff(a) == 4) b = 2;
         if (eff(a) == 4) d = d % 14;
         op(b, a, d);
         if (i % 50 == 0) sync;
         if (i % 1000 == 999) rst((i / 1000) & 1, 3);
      end
      sync;
      complete_run;
   end
endmodule

/* File: bdma_core.v */
`timescale 1ns/1ps
`include "bdma_defs.vh"
// What this block does
// - Special register window decodes the same in every bank.
// - Unused special locations read undefined (zero here); writes are ignored.
// - Display memory reachable only through pointer one and its indirect port.
// - Bank one accesses below 40H land on bank zero special registers.
// - Bank one reads past last display location return zero.
// - Special registers sit at 00H to 3FH in fixed order.
// - Indirect ports hold nothing; accesses go to the pointed location.
// - Port zero pair always hits bank zero; port one follows bank select.
// - Indirect access to an indirect port reads zero, writes nothing.
// - Both pointers are real registers, writable and incrementable.
// - Bank select value is the bank number.
// - Reset clears bank select, except watchdog reset while powered down.
// - Direct addressing always reaches bank zero.
// - Add results land in the working register, not memory; increment and decrement write the location.
// - Memory to memory moves pass through the working register.
// - Banks two to twelve hold only general purpose memory.
// - Display region of bank one drives the display directly.
module bdma_core (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   input wire wdt_pd_reset_i,
   // Core access request
   input wire [`BDMA_OP_W-1:0] op_i,
   input wire [`BDMA_AW-1:0] addr_i,
   input wire [`BDMA_DW-1:0] wdata_i,
   // Read answer
   output reg [`BDMA_DW-1:0] rdata_o,
   output reg rvalid_o,
   // Register state
   output reg [`BDMA_DW-1:0] wreg_o,
   output reg [`BDMA_DW-1:0] bank_o,
   output reg [`BDMA_DW-1:0] ptr0_o,
   output reg [`BDMA_DW-1:0] ptr1_o,
   // Display write tap
   output reg disp_we_o,
   output reg [`BDMA_AW-1:0] disp_addr_o,
   output reg [`BDMA_DW-1:0] disp_data_o
);
   localparam FW = `BDMA_BANK_W + `BDMA_AW;

   reg [`BDMA_DW-1:0] ptr0_r;
   reg [`BDMA_DW-1:0] ptr1_r;
   reg [`BDMA_DW-1:0] bank_r;
   reg [`BDMA_DW-1:0] wreg_r;

   // Resolved target of the current access
   reg tgt_sfr;
   reg tgt_null;
   reg tgt_zero;
   reg [`BDMA_AW-1:0] tgt_off;
   reg [`BDMA_BANK_W-1:0] tgt_bank;
   reg [`BDMA_DW-1:0] cur_val;
   reg [`BDMA_DW-1:0] new_val;
   reg do_wr;
   reg do_rd;
   reg tgt_valid_bank;
   wire [`BDMA_DW-1:0] ram_rd;

   // True for an offset inside the special register window
   function is_sfr;
      input [`BDMA_AW-1:0] a;
      begin
         is_sfr = (a <= `BDMA_SFR_LAST);
      end
   endfunction

   // Reads of an implemented special register; others read as zero
   function [`BDMA_DW-1:0] sfr_read;
      input [`BDMA_AW-1:0] a;
      input [`BDMA_DW-1:0] p0;
      input [`BDMA_DW-1:0] p1;
      input [`BDMA_DW-1:0] bk;
      input [`BDMA_DW-1:0] w;
      begin
         case (a)
            `BDMA_ADDR_PTR0: sfr_read = p0;
            `BDMA_ADDR_PTR1: sfr_read = p1;
            `BDMA_ADDR_BANK: sfr_read = bk;
            `BDMA_ADDR_WREG: sfr_read = w;
            default: sfr_read = `BDMA_ZERO;
         endcase
      end
   endfunction

   // Address resolution: direct, via pointer zero, or via pointer one
   always @* begin
      tgt_null = 1'b0;
      tgt_zero = 1'b0;
      tgt_off = addr_i;
      tgt_bank = `BDMA_BANK0;
      if (addr_i == `BDMA_ADDR_IND0) begin
         tgt_off = ptr0_r;
         tgt_bank = `BDMA_BANK0;
         if (ptr0_r == `BDMA_ADDR_IND0 || ptr0_r == `BDMA_ADDR_IND1) begin
            tgt_null = 1'b1;
         end
      end else if (addr_i == `BDMA_ADDR_IND1) begin
         tgt_off = ptr1_r;
         tgt_bank = bank_r[`BDMA_BANK_W-1:0];
         if (ptr1_r == `BDMA_ADDR_IND0 || ptr1_r == `BDMA_ADDR_IND1) begin
            tgt_null = 1'b1;
         end
      end
      tgt_sfr = is_sfr(tgt_off); // bank ignored in window
      // Bank numbers above the top bank are not implemented; those with low four bits zero reach bank zero
      tgt_valid_bank = (bank_r < `BDMA_BANKS) || (tgt_bank == `BDMA_BANK0);
      // Bank one holds display memory only up to its last location
      if (!tgt_sfr && tgt_bank == `BDMA_BANK1 && tgt_off > `BDMA_DISP_LAST) begin
         tgt_zero = 1'b1;
      end
      if (!tgt_sfr && !tgt_valid_bank) begin
         tgt_zero = 1'b1;
      end
   end

   // Current value of the target location
   always @* begin
      if (tgt_null || tgt_zero) begin
         cur_val = `BDMA_ZERO;
      end else if (tgt_sfr) begin
         cur_val = sfr_read(tgt_off, ptr0_r, ptr1_r, bank_r, wreg_r);
      end else begin
         cur_val = ram_rd;
      end
   end

   // Operation decode; memory to memory moves do not exist here
   always @* begin
      do_wr = 1'b0;
      do_rd = 1'b0;
      new_val = cur_val;
      case (op_i)
         `BDMA_OP_RD: begin
            do_rd = 1'b1;
         end
         `BDMA_OP_WR: begin
            do_wr = 1'b1;
            new_val = wdata_i;
         end
         `BDMA_OP_INC: begin
            do_wr = 1'b1;
            new_val = cur_val + `BDMA_ONE;
         end
         `BDMA_OP_DEC: begin
            do_wr = 1'b1;
            new_val = cur_val - `BDMA_ONE;
         end
         `BDMA_OP_STW: begin
            do_wr = 1'b1;
            new_val = wreg_r;
         end
         default: begin
            do_wr = 1'b0;
         end
      endcase
   end

   // Only real general memory in an implemented bank is written; a request held
   // through reset must not keep hitting the array on every reset edge
   wire ram_we = do_wr && rst_n_i && !tgt_null && !tgt_zero && !tgt_sfr;
   wire [FW-1:0] ram_addr = {tgt_bank, tgt_off};

   bdma_ram u_ram (
      .clk_i(clk_i),
      .wr_en_i(ram_we),
      .wr_addr_i(ram_addr),
      .wr_data_i(new_val),
      .rd_addr_i(ram_addr),
      .rd_data_o(ram_rd)
   );

   // Special registers; a write to a pointer may come directly or indirectly
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         ptr0_r <= `BDMA_ZERO;
         ptr1_r <= `BDMA_ZERO;
         wreg_r <= `BDMA_ZERO;
         // Bank survives a watchdog reset taken while powered down
         if (!wdt_pd_reset_i) begin
            bank_r <= `BDMA_ZERO;
         end
      end else begin
         if (do_wr && tgt_sfr && !tgt_null) begin
            case (tgt_off)
               `BDMA_ADDR_PTR0: ptr0_r <= new_val;
               `BDMA_ADDR_PTR1: ptr1_r <= new_val;
               `BDMA_ADDR_BANK: bank_r <= new_val;
               `BDMA_ADDR_WREG: wreg_r <= new_val;
               default: ptr0_r <= ptr0_r;
            endcase
         end
         // Loads and adds keep results in the working register
         if (op_i == `BDMA_OP_LDW) begin
            wreg_r <= cur_val;
         end else if (op_i == `BDMA_OP_ADDW) begin
            wreg_r <= wreg_r + cur_val;
         end
      end
   end

   // Registered answer and status mirrors
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= `BDMA_ZERO;
         rvalid_o <= 1'b0;
         wreg_o <= `BDMA_ZERO;
         // Mirror keeps the surviving bank just like the register itself
         if (!wdt_pd_reset_i) begin
            bank_o <= `BDMA_ZERO;
         end
         ptr0_o <= `BDMA_ZERO;
         ptr1_o <= `BDMA_ZERO;
      end else begin
         rvalid_o <= do_rd;
         if (do_rd) begin
            rdata_o <= cur_val;
         end
         wreg_o <= wreg_r;
         bank_o <= bank_r;
         ptr0_o <= ptr0_r;
         ptr1_o <= ptr1_r;
      end
   end

   // Display tap: only indirect port one can hit bank one general memory
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         disp_we_o <= 1'b0;
         disp_addr_o <= `BDMA_ZERO;
         disp_data_o <= `BDMA_ZERO;
      end else begin
         disp_we_o <= ram_we && (tgt_bank == `BDMA_BANK1);
         if (ram_we && tgt_bank == `BDMA_BANK1) begin
            disp_addr_o <= tgt_off;
            disp_data_o <= new_val;
         end
      end
   end
endmodule

/* File: bdma_core_properties.sv */
`timescale 1ns/1ps
// Port checks on the banked memory block
module bdma_chk (
   // Clock, reset and request
   input wire clk_i,
   input wire rst_n_i,
   input wire wdt_pd_reset_i,
   input wire [2:0] op_i,
   input wire [7:0] addr_i,
   input wire [7:0] wdata_i,
   // Answers
   input wire [7:0] rdata_o,
   input wire rvalid_o,
   input wire [7:0] wreg_o,
   input wire [7:0] bank_o,
   input wire [7:0] ptr0_o,
   input wire [7:0] ptr1_o,
   input wire disp_we_o,
   input wire [7:0] disp_addr_o,
   input wire [7:0] disp_data_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_read_valid:
   assert property (rvalid_o == ($past(op_i) == 3'h1)) else $error("read strobe wrong");
   a_reset_clear:
   assert property ($rose(rst_n_i) |-> {ptr0_o, ptr1_o, wreg_o} == 24'h00_0000 && !rvalid_o)
      else $error("reset values wrong");
   a_bank_clear:
   assert property ($rose(rst_n_i) && !$past(wdt_pd_reset_i) |-> bank_o == 8'h0_0)
      else $error("bank not cleared");
   a_bank_kept:
   assert property ($rose(rst_n_i) && $past(wdt_pd_reset_i) |-> bank_o == $past(bank_o, 3))
      else $error("bank lost");
   a_bank_write:
   assert property (op_i == 3'h2 && addr_i == 8'h0_4 |=> ##1 bank_o == $past(wdata_i, 2))
      else $error("bank write lost");
   a_unused_zero:
   assert property (op_i == 3'h1 && addr_i > 8'h0_5 && addr_i < 8'h4_0 |=> rdata_o == 8'h0_0)
      else $error("unused read not zero");
   a_direct_nodisp:
   assert property (op_i == 3'h2 && addr_i > 8'h3_F |=> !disp_we_o) else $error("direct display");
   a_disp_bank1:
   assert property (op_i == 3'h2 && addr_i == 8'h0_2 && bank_o == 8'h0_1 && ptr1_o > 8'h3_F
      && ptr1_o < 8'hC_0 && $past(op_i) == 3'h0 && $past(op_i, 2) == 3'h0 |=> disp_we_o
      && disp_addr_o == $past(ptr1_o) && disp_data_o == $past(wdata_i)) else $error("display");
endmodule
bind bdma_core bdma_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .wdt_pd_reset_i(wdt_pd_reset_i),
   .op_i(op_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
   .wreg_o(wreg_o), .bank_o(bank_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o), .disp_we_o(disp_we_o),
   .disp_addr_o(disp_addr_o), .disp_data_o(disp_data_o));

/* File: bdma_cpu_model.sv */
`timescale 1ns/1ps
// Processor side: one request held per cycle
module bdma_cpu (
   // Request
   output reg [2:0] op_o,
   output reg [7:0] addr_o,
   output reg [7:0] wdata_o
);
   // Idle request at time zero
   initial begin
      op_o = 3'h0;
      addr_o = 8'h0_0;
      wdata_o = 8'h0_0;
   end
   // Idle cycles flip the lines so stale values never look valid
   task put(input [2:0] o, input [7:0] a, input [7:0] d);
      begin
         op_o = o;
         addr_o = (o != 3'h0) ? a : ~addr_o;
         wdata_o = (o != 3'h0) ? d : ~wdata_o;
      end
   endtask
endmodule

/* File: bdma_defs.vh */
`ifndef BDMA_DEFS_VH
`define BDMA_DEFS_VH
// Data width and address layout
`define BDMA_DW 8
`define BDMA_AW 8
`define BDMA_BANKS 13
`define BDMA_BANK_W 4
// Special function register offsets
`define BDMA_ADDR_IND0 8'h0_0
`define BDMA_ADDR_PTR0 8'h0_1
`define BDMA_ADDR_IND1 8'h0_2
`define BDMA_ADDR_PTR1 8'h0_3
`define BDMA_ADDR_BANK 8'h0_4
`define BDMA_ADDR_WREG 8'h0_5
// Special purpose area ends here; general memory starts above it
`define BDMA_SFR_LAST 8'h3_F
`define BDMA_GP_FIRST 8'h4_0
`define BDMA_GP_LAST 8'hF_F
// Last implemented display location in bank 1
`define BDMA_DISP_LAST 8'hB_F
// Constants
`define BDMA_ZERO 8'h0_0
`define BDMA_ONE 8'h0_1
`define BDMA_BANK0 4'h0
`define BDMA_BANK1 4'h1
// Core operation codes
`define BDMA_OP_W 3
`define BDMA_OP_NONE 3'h0
`define BDMA_OP_RD 3'h1
`define BDMA_OP_WR 3'h2
`define BDMA_OP_INC 3'h3
`define BDMA_OP_DEC 3'h4
`define BDMA_OP_LDW 3'h5
`define BDMA_OP_STW 3'h6
`define BDMA_OP_ADDW 3'h7
`endif

/* File: bdma_ram.v */
`timescale 1ns/1ps
`include "bdma_defs.vh"
// One general purpose array for all banks, written synchronously and read combinationally
module bdma_ram (
   // Clock
   input wire clk_i,
   // Write side
   input wire wr_en_i,
   input wire [`BDMA_BANK_W+`BDMA_AW-1:0] wr_addr_i,
   input wire [`BDMA_DW-1:0] wr_data_i,
   // Read side
   input wire [`BDMA_BANK_W+`BDMA_AW-1:0] rd_addr_i,
   output wire [`BDMA_DW-1:0] rd_data_o
);
   reg [`BDMA_DW-1:0] mem_r [0:(`BDMA_BANKS<<`BDMA_AW)-1];

   // Combinational read keeps the core's read-modify-write in one cycle
   assign rd_data_o = mem_r[rd_addr_i];

   // Plain write port; no reset, contents are undefined at power up
   always @(posedge clk_i) begin
      if (wr_en_i) begin
         mem_r[wr_addr_i] <= wr_data_i;
      end
   end
endmodule
